// ==== logic/ats_regs.vh ====
// Purpose: constants shared by the addressable scan switch files
// Assumes: included by bare name from the design files
// Notes:   frame layout is start bit, command, address msb first, stop bit
`ifndef ATS_REGS_VH
`define ATS_REGS_VH

// ----------------------------------------------------------------
// addressing frame
// ----------------------------------------------------------------
`define ATS_ADDR_W      10
`define ATS_CMD_W       2
`define ATS_FRAME_W     12
`define ATS_CNT_W       4
`define ATS_FRAME_BITS  4'hC
`define ATS_ACK_BITS    4'hA
`define ATS_CNT_ZERO    4'h0
`define ATS_CNT_ONE     4'h1
`define ATS_START_LVL   1'b0
`define ATS_STOP_LVL    1'b1
`define ATS_CMD_MSB     11
`define ATS_CMD_LSB     10
`define ATS_ADDR_MSB    9

// ----------------------------------------------------------------
// addressing commands
// ----------------------------------------------------------------
`define ATS_CMD_SELECT  2'h0
`define ATS_CMD_MCAST   2'h1
`define ATS_CMD_RESET   2'h2
`define ATS_CMD_OFF     2'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ATS_MS_HOLD_RST 1'b1
`define ATS_ACK_IDLE    1'b1

`endif

// ==== logic/ats_tap_follow.v ====
// Purpose: copy of the test-access-port controller, stepped on clock rises
// Assumes: rise_i is a one-cycle pulse per upstream clock rising edge
// Notes:   stable_o marks states where addressing frames are heard
`timescale 1ns/10ps
module ats_tap_follow (
   input  wire       mclk_i,
   input  wire       arst_i,
   input  wire       rise_i,
   input  wire       tms_i,
   output wire [3:0] state_o,
   output wire       stable_o
);
   localparam TLR  = 4'h0;
   localparam RTI  = 4'h1;
   localparam SDRS = 4'h2;
   localparam CDR  = 4'h3;
   localparam SDR  = 4'h4;
   localparam E1DR = 4'h5;
   localparam PDR  = 4'h6;
   localparam E2DR = 4'h7;
   localparam UDR  = 4'h8;
   localparam SIRS = 4'h9;
   localparam CIR  = 4'hA;
   localparam SIR  = 4'hB;
   localparam E1IR = 4'hC;
   localparam PIR  = 4'hD;
   localparam E2IR = 4'hE;
   localparam UIR  = 4'hF;

   reg [3:0] state_ff;
   reg [3:0] nxt_state;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always @* begin
      case (state_ff)
         TLR:     nxt_state = tms_i ? TLR  : RTI;
         RTI:     nxt_state = tms_i ? SDRS : RTI;
         SDRS:    nxt_state = tms_i ? SIRS : CDR;
         CDR:     nxt_state = tms_i ? E1DR : SDR;
         SDR:     nxt_state = tms_i ? E1DR : SDR;
         E1DR:    nxt_state = tms_i ? UDR  : PDR;
         PDR:     nxt_state = tms_i ? E2DR : PDR;
         E2DR:    nxt_state = tms_i ? UDR  : SDR;
         UDR:     nxt_state = tms_i ? SDRS : RTI;
         SIRS:    nxt_state = tms_i ? TLR  : CIR;
         CIR:     nxt_state = tms_i ? E1IR : SIR;
         SIR:     nxt_state = tms_i ? E1IR : SIR;
         E1IR:    nxt_state = tms_i ? UIR  : PIR;
         PIR:     nxt_state = tms_i ? E2IR : PIR;
         E2IR:    nxt_state = tms_i ? UIR  : SIR;
         UIR:     nxt_state = tms_i ? SDRS : RTI;
         default: nxt_state = TLR;
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always @(posedge mclk_i or posedge arst_i) begin
      if (arst_i) begin
         state_ff <= TLR;
      end else if (rise_i) begin
         state_ff <= nxt_state;
      end
   end

   assign state_o  = state_ff;
   assign stable_o = (state_ff == TLR) || (state_ff == RTI) ||
                     (state_ff == PDR) || (state_ff == PIR);
endmodule

// ==== logic/ats_switch.v ====
// Purpose: addressable switch joining a multidrop upstream test port to a board port
// Assumes: mclk_i well above the upstream test clock; pins arrive asynchronously
// Notes:   clock, reset and connected data paths are plain buffers, no retiming
`timescale 1ns/10ps
`include "ats_regs.vh"
module ats_switch (
   input  wire                   mclk_i,
   input  wire                   rst_i,
   input  wire                   upstream_test_clock_i,
   input  wire                   upstream_mode_select_i,
   input  wire                   upstream_data_in_i,
   input  wire                   upstream_test_reset_n_i,
   output wire                   upstream_data_out_o,
   output wire                   upstream_data_out_oe_o,
   output wire                   downstream_test_clock_o,
   output wire                   downstream_mode_select_o,
   input  wire                   downstream_data_in_i,
   output wire                   downstream_data_out_o,
   output wire                   downstream_data_out_oe_o,
   output wire                   downstream_test_reset_n_o,
   input  wire                   forced_link_pin_n_i,
   input  wire [`ATS_ADDR_W-1:0] board_identity_i,
   output wire                   link_active_n_o
);
   localparam ST_OFF     = 3'h0;
   localparam ST_ON      = 3'h1;
   localparam ST_MCAST   = 3'h2;
   localparam ST_RESET   = 3'h3;
   localparam ST_FORCED  = 3'h4;
   localparam ST_FRC_RST = 3'h5;
   localparam ST_TST_RST = 3'h6;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   wire                    arst;
   reg                     tck_s1_ff;
   reg                     tck_s2_ff;
   reg                     tck_d_ff;
   reg                     tms_s1_ff;
   reg                     tms_s2_ff;
   reg                     tdi_s1_ff;
   reg                     tdi_s2_ff;
   reg                     fl_n_s1_ff;
   reg                     fl_n_s2_ff;
   reg                     trst_n_s1_ff;
   reg                     trst_n_s2_ff;
   reg  [`ATS_ADDR_W-1:0]  id_s1_ff;
   reg  [`ATS_ADDR_W-1:0]  id_s2_ff;
   wire                    tck_rise;
   wire                    tck_fall;
   wire [3:0]              tap_state;
   wire                    tap_stable;
   reg  [2:0]              status_ff;
   reg  [2:0]              pend_status_ff;
   reg  [2:0]              eff_status;
   reg                     rx_busy_ff;
   reg  [`ATS_CNT_W-1:0]   rx_cnt_ff;
   reg  [`ATS_FRAME_W-1:0] rx_sr_ff;
   reg                     ack_on_ff;
   reg                     ack_bit_ff;
   reg  [`ATS_CNT_W-1:0]   ack_cnt_ff;
   reg  [`ATS_ADDR_W-1:0]  ack_sr_ff;
   reg                     ms_hold_ff;
   wire                    ack_busy;
   wire                    listen;
   wire [`ATS_CMD_W-1:0]   rx_cmd;
   wire [`ATS_ADDR_W-1:0]  rx_addr;
   wire                    addr_match;
   wire                    link_dn_data;
   wire                    link_up_data;
   wire                    link_ms;
   wire                    ms_force_hi;

   assign arst = rst_i | ~upstream_test_reset_n_i;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   always @(posedge mclk_i) begin
      tck_s1_ff    <= upstream_test_clock_i;
      tck_s2_ff    <= tck_s1_ff;
      tck_d_ff     <= tck_s2_ff;
      tms_s1_ff    <= upstream_mode_select_i;
      tms_s2_ff    <= tms_s1_ff;
      tdi_s1_ff    <= upstream_data_in_i;
      tdi_s2_ff    <= tdi_s1_ff;
      fl_n_s1_ff   <= forced_link_pin_n_i;
      fl_n_s2_ff   <= fl_n_s1_ff;
      trst_n_s1_ff <= upstream_test_reset_n_i;
      trst_n_s2_ff <= trst_n_s1_ff;
   end

   genvar gi;
   generate
      for (gi = 0; gi < `ATS_ADDR_W; gi = gi + 1) begin : g_id_sync
         always @(posedge mclk_i) begin
            id_s1_ff[gi] <= board_identity_i[gi];
            id_s2_ff[gi] <= id_s1_ff[gi];
         end
      end
   endgenerate

   assign tck_rise = tck_s2_ff & ~tck_d_ff;
   assign tck_fall = ~tck_s2_ff & tck_d_ff;

   // ----------------------------------------------------------------
   // controller state follower
   // ----------------------------------------------------------------
   ats_tap_follow u_tap (
      .mclk_i   (mclk_i),
      .arst_i   (arst),
      .rise_i   (tck_rise),
      .tms_i    (tms_s2_ff),
      .state_o  (tap_state),
      .stable_o (tap_stable)
   );

   // ----------------------------------------------------------------
   // effective connect status
   // ----------------------------------------------------------------
   always @* begin
      if (!trst_n_s2_ff) begin
         eff_status = fl_n_s2_ff ? ST_TST_RST : ST_FRC_RST;
      end else if (!fl_n_s2_ff) begin
         eff_status = ST_FORCED;
      end else begin
         eff_status = status_ff;
      end
   end

   // ----------------------------------------------------------------
   // frame receiver and acknowledge
   // ----------------------------------------------------------------
   assign ack_busy   = ack_on_ff | (ack_cnt_ff != `ATS_CNT_ZERO);
   assign listen     = tap_stable & fl_n_s2_ff & trst_n_s2_ff & ~ack_busy;
   assign rx_cmd     = rx_sr_ff[`ATS_CMD_MSB:`ATS_CMD_LSB];
   assign rx_addr    = rx_sr_ff[`ATS_ADDR_MSB:0];
   assign addr_match = (rx_addr == id_s2_ff);

   always @(posedge mclk_i or posedge arst) begin
      if (arst) begin
         status_ff      <= ST_OFF;
         pend_status_ff <= ST_OFF;
         rx_busy_ff     <= 1'b0;
         rx_cnt_ff      <= `ATS_CNT_ZERO;
         rx_sr_ff       <= {`ATS_FRAME_W{1'b0}};
         ack_on_ff      <= 1'b0;
         ack_bit_ff     <= `ATS_ACK_IDLE;
         ack_cnt_ff     <= `ATS_CNT_ZERO;
         ack_sr_ff      <= {`ATS_ADDR_W{1'b0}};
      end else begin
         if (tck_rise) begin
            if (!listen) begin
               rx_busy_ff <= 1'b0;
            end else if (!rx_busy_ff) begin
               if (tdi_s2_ff == `ATS_START_LVL) begin
                  rx_busy_ff <= 1'b1;
                  rx_cnt_ff  <= `ATS_CNT_ZERO;
               end
            end else if (rx_cnt_ff != `ATS_FRAME_BITS) begin
               rx_sr_ff  <= {rx_sr_ff[`ATS_FRAME_W-2:0], tdi_s2_ff};
               rx_cnt_ff <= rx_cnt_ff + `ATS_CNT_ONE;
            end else begin
               rx_busy_ff <= 1'b0;
               if (tdi_s2_ff == `ATS_STOP_LVL) begin
                  case (rx_cmd)
                     `ATS_CMD_SELECT: begin
                        if (addr_match) begin
                           ack_sr_ff      <= rx_addr;
                           ack_cnt_ff     <= `ATS_ACK_BITS;
                           pend_status_ff <= ST_ON;
                        end else begin
                           status_ff <= ST_OFF;
                        end
                     end
                     `ATS_CMD_MCAST: begin
                        status_ff <= addr_match ? ST_MCAST : ST_OFF;
                     end
                     `ATS_CMD_RESET: begin
                        status_ff <= ST_RESET;
                     end
                     default: begin
                        status_ff <= ST_OFF;
                     end
                  endcase
               end
            end
         end
         if (tck_fall) begin
            if (ack_cnt_ff != `ATS_CNT_ZERO) begin
               ack_on_ff  <= 1'b1;
               ack_bit_ff <= ack_sr_ff[`ATS_ADDR_W-1];
               ack_sr_ff  <= {ack_sr_ff[`ATS_ADDR_W-2:0], 1'b0};
               ack_cnt_ff <= ack_cnt_ff - `ATS_CNT_ONE;
            end else if (ack_on_ff) begin
               ack_on_ff  <= 1'b0;
               ack_bit_ff <= `ATS_ACK_IDLE;
               status_ff  <= pend_status_ff;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // downstream mode select hold
   // ----------------------------------------------------------------
   assign link_ms     = (eff_status == ST_FORCED) || (eff_status == ST_MCAST) ||
                        (eff_status == ST_ON);
   assign ms_force_hi = (eff_status == ST_FRC_RST) || (eff_status == ST_RESET) ||
                        (eff_status == ST_TST_RST);

   always @(posedge mclk_i or posedge arst) begin
      if (arst) begin
         ms_hold_ff <= `ATS_MS_HOLD_RST;
      end else if (link_ms) begin
         ms_hold_ff <= tms_s2_ff;
      end else if (ms_force_hi) begin
         ms_hold_ff <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // port buffers
   // ----------------------------------------------------------------
   assign link_dn_data = link_ms || (eff_status == ST_FRC_RST);
   assign link_up_data = (eff_status == ST_FORCED) || (eff_status == ST_FRC_RST) ||
                         (eff_status == ST_ON);

   assign downstream_test_clock_o   = upstream_test_clock_i;
   assign downstream_test_reset_n_o = upstream_test_reset_n_i;
   assign downstream_mode_select_o  = link_ms ? upstream_mode_select_i : ms_hold_ff;
   assign downstream_data_out_o     = upstream_data_in_i;
   assign downstream_data_out_oe_o  = link_dn_data;
   assign upstream_data_out_o       = link_up_data ? downstream_data_in_i : ack_bit_ff;
   assign upstream_data_out_oe_o    = link_up_data | ack_on_ff;
   assign link_active_n_o           = ~link_dn_data;
endmodule

// ==== test/ats_switch_asserts.sv ====
// Purpose: port checks on the addressable scan switch
// Assumes: test clock period is eight mclk cycles
// Notes:   ack window counted in mclk cycles
`timescale 1ns/10ps
module ats_switch_asserts (
   input wire       mclk_i,
   input wire       rst_i,
   input wire       upstream_test_clock_i,
   input wire       upstream_mode_select_i,
   input wire       upstream_data_in_i,
   input wire       upstream_test_reset_n_i,
   input wire       upstream_data_out_o,
   input wire       upstream_data_out_oe_o,
   input wire       downstream_test_clock_o,
   input wire       downstream_mode_select_o,
   input wire       downstream_data_in_i,
   input wire       downstream_data_out_o,
   input wire       downstream_data_out_oe_o,
   input wire       downstream_test_reset_n_o,
   input wire       forced_link_pin_n_i,
   input wire [9:0] board_identity_i,
   input wire       link_active_n_o
);
   reg  [7:0] ack_cnt_ff;
   wire       ack_on_w = upstream_data_out_oe_o & link_active_n_o;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i)
         ack_cnt_ff <= 8'h00;
      else
         ack_cnt_ff <= ack_on_w ? ack_cnt_ff + 8'h01 : 8'h00;
   end
   a_clk_pass: assert property (downstream_test_clock_o == upstream_test_clock_i)
      else $error("test clock not passed down");
   a_rst_pass: assert property (downstream_test_reset_n_o == upstream_test_reset_n_i)
      else $error("test reset not passed down");
   a_dn_data: assert property (
      downstream_data_out_oe_o |-> downstream_data_out_o == upstream_data_in_i)
      else $error("data not passed down");
   a_link_oe: assert property (link_active_n_o == !downstream_data_out_oe_o)
      else $error("link flag and down enable disagree");
   a_up_link: assert property (
      !link_active_n_o && upstream_data_out_oe_o |->
      upstream_data_out_o == downstream_data_in_i)
      else $error("board data not passed up");
   a_ms_pass: assert property (
      !link_active_n_o && upstream_test_reset_n_i && $past(upstream_test_reset_n_i, 4)
      |-> downstream_mode_select_o == upstream_mode_select_i)
      else $error("mode select not passed down");
   a_trst_ms: assert property (
      !upstream_test_reset_n_i && !$past(upstream_test_reset_n_i, 3)
      |-> downstream_mode_select_o)
      else $error("mode select not forced high");
   a_ms_hold: assert property (
      link_active_n_o && $past(link_active_n_o) |-> !$fell(downstream_mode_select_o))
      else $error("held mode select dropped");
   a_ack_edge: assert property (
      ack_on_w && $changed(upstream_data_out_o) |-> !upstream_test_clock_i)
      else $error("ack bit changed with test clock high");
   a_ack_len: assert property (
      disable iff (rst_i || !upstream_test_reset_n_i)
      ack_cnt_ff > 8'h08 && !ack_on_w |-> ack_cnt_ff == 8'h50)
      else $error("ack window not ten test clocks");
endmodule
bind ats_switch ats_switch_asserts u_ats_switch_asserts (
   .mclk_i                    (mclk_i),
   .rst_i                     (rst_i),
   .upstream_test_clock_i     (upstream_test_clock_i),
   .upstream_mode_select_i    (upstream_mode_select_i),
   .upstream_data_in_i        (upstream_data_in_i),
   .upstream_test_reset_n_i   (upstream_test_reset_n_i),
   .upstream_data_out_o       (upstream_data_out_o),
   .upstream_data_out_oe_o    (upstream_data_out_oe_o),
   .downstream_test_clock_o   (downstream_test_clock_o),
   .downstream_mode_select_o  (downstream_mode_select_o),
   .downstream_data_in_i      (downstream_data_in_i),
   .downstream_data_out_o     (downstream_data_out_o),
   .downstream_data_out_oe_o  (downstream_data_out_oe_o),
   .downstream_test_reset_n_o (downstream_test_reset_n_o),
   .forced_link_pin_n_i       (forced_link_pin_n_i),
   .board_identity_i          (board_identity_i),
   .link_active_n_o           (link_active_n_o)
);

// ==== test/ats_host_model.sv ====
// Purpose: backplane test controller driving the upstream port
// Assumes: called from the bench on mclk falling edges
// Notes:   one test clock period is eight mclk cycles
`timescale 1ns/10ps
module ats_host_model (
   input  wire mclk_i,
   input  wire tdo_i,
   input  wire tdo_oe_i,
   output reg  tck_o = 1'b1,
   output reg  tms_o = 1'b1,
   output reg  tdi_o = 1'b1
);
   logic rx_q[$];
   logic last_ff = 1'b1;
   wire  line_w = tdo_oe_i ? tdo_i : ~last_ff;
   always @(negedge mclk_i) begin
      if (tdo_oe_i)
         last_ff <= tdo_i;
   end
   task tick(input logic ms, input logic di);
      begin
         tck_o = 1'b0;
         tms_o = ms;
         tdi_o = di;
         repeat (4) @(negedge mclk_i);
         tck_o = 1'b1;
         rx_q.push_back(line_w);
         repeat (4) @(negedge mclk_i);
      end
   endtask
   task frame(input logic [1:0] c, input logic [9:0] a);
      integer k;
      begin
         tick(1'b0, 1'b0);
         for (k = 1; k >= 0; k--)
            tick(1'b0, c[k]);
         for (k = 9; k >= 0; k--)
            tick(1'b0, a[k]);
         tick(1'b0, 1'b1);
         rx_q.delete();
         repeat (11) tick(1'b0, 1'b1);
      end
   endtask
endmodule

// ==== test/ats_switch_bench.sv ====
// Purpose: self-checking bench for the addressable scan switch
// Assumes: host model drives the upstream port
// Notes:   st is the expected status, 0 off 1 on 2 multicast 3 reset
`timescale 1ns/10ps
module ats_switch_bench;
   logic       mclk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       upstream_test_reset_n_i = 1'b1;
   logic       forced_link_pin_n_i = 1'b1;
   logic       downstream_data_in_i = 1'b1;
   logic [9:0] board_identity_i = 10'h000;
   wire        upstream_test_clock_i, upstream_mode_select_i, upstream_data_in_i;
   wire        upstream_data_out_o, upstream_data_out_oe_o, downstream_test_clock_o;
   wire        downstream_mode_select_o, downstream_data_out_o, downstream_data_out_oe_o;
   wire        downstream_test_reset_n_o, link_active_n_o;
   integer     n_mismatch = 0;
   integer     checks_done = 0;
   integer     st = 0;
   integer     seed = 32'h7AD1ABAC;
   always #20 mclk_i = ~mclk_i;
   ats_switch u_ats_switch (
      .mclk_i                    (mclk_i),
      .rst_i                     (rst_i),
      .upstream_test_clock_i     (upstream_test_clock_i),
      .upstream_mode_select_i    (upstream_mode_select_i),
      .upstream_data_in_i        (upstream_data_in_i),
      .upstream_test_reset_n_i   (upstream_test_reset_n_i),
      .upstream_data_out_o       (upstream_data_out_o),
      .upstream_data_out_oe_o    (upstream_data_out_oe_o),
      .downstream_test_clock_o   (downstream_test_clock_o),
      .downstream_mode_select_o  (downstream_mode_select_o),
      .downstream_data_in_i      (downstream_data_in_i),
      .downstream_data_out_o     (downstream_data_out_o),
      .downstream_data_out_oe_o  (downstream_data_out_oe_o),
      .downstream_test_reset_n_o (downstream_test_reset_n_o),
      .forced_link_pin_n_i       (forced_link_pin_n_i),
      .board_identity_i          (board_identity_i),
      .link_active_n_o           (link_active_n_o)
   );
   ats_host_model u_ats_host_model (.mclk_i(mclk_i), .tdo_i(upstream_data_out_o),
      .tdo_oe_i(upstream_data_out_oe_o), .tck_o(upstream_test_clock_i),
      .tms_o(upstream_mode_select_i), .tdi_o(upstream_data_in_i));
   task summarize;
      begin
         $display("checks %0d mismatches %0d", checks_done, n_mismatch);
         if (n_mismatch == 0 && checks_done > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task wt(input integer n);
      repeat (n) @(negedge mclk_i);
   endtask
   task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      begin
         checks_done++;
         if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task chk_st;
      integer s;
      logic   lk;
      logic   dr;
      begin
         s = !upstream_test_reset_n_i ? (forced_link_pin_n_i ? 4 : 6)
            : (forced_link_pin_n_i ? st : 5);
         lk = s == 1 || s == 2 || s >= 5;
         dr = s == 1 || s >= 5;
         chk("link flag", !lk, link_active_n_o);
         chk("down oe", lk, downstream_data_out_oe_o);
         chk("up oe", dr, upstream_data_out_oe_o);
         chk("down clk", upstream_test_clock_i, downstream_test_clock_o);
         chk("down rst", upstream_test_reset_n_i, downstream_test_reset_n_o);
         if (lk)
            chk("down data", upstream_data_in_i, downstream_data_out_o);
         if (dr)
            chk("up data", downstream_data_in_i, upstream_data_out_o);
         if (s == 3 || s == 4 || s == 6)
            chk("down ms", 1'b1, downstream_mode_select_o);
         if (s == 1 || s == 2 || s == 5)
            chk("down ms", upstream_mode_select_i, downstream_mode_select_o);
      end
   endtask
   task send(input logic [1:0] c, input logic [9:0] a, input logic ok);
      integer k;
      begin
         u_ats_host_model.frame(c, a);
         if (ok && forced_link_pin_n_i) begin
            if (c == 2'h0 && a === board_identity_i) begin
               st = 1;
               for (k = 0; k < 10; k++)
                  chk("ack bit", a[9 - k], u_ats_host_model.rx_q[k]);
            end else
               st = (c == 2'h1 && a === board_identity_i) ? 2 : (c == 2'h2) ? 3 : 0;
         end
         wt(4);
         chk_st;
      end
   endtask
   initial begin
      repeat (100000) @(posedge mclk_i);
      n_mismatch++;
      summarize;
   end
   initial begin
      board_identity_i = 10'($random(seed));
      wt(3);
      rst_i = 1'b0;
      wt(4);
      chk_st;
      upstream_test_reset_n_i = 1'b0;
      wt(4);
      chk_st;
      forced_link_pin_n_i = 1'b0;
      downstream_data_in_i = 1'($random(seed));
      wt(4);
      chk_st;
      upstream_test_reset_n_i = 1'b1;
      wt(4);
      send(2'h0, board_identity_i, 1'b1);
      forced_link_pin_n_i = 1'b1;
      wt(4);
      chk_st;
      send(2'h0, board_identity_i, 1'b1);
      downstream_data_in_i = ~downstream_data_in_i;
      wt(1);
      chk_st;
      send(2'h3, 10'h000, 1'b1);
      chk("held ms", 1'b0, downstream_mode_select_o);
      send(2'h0, board_identity_i ^ 10'h200, 1'b1);
      send(2'h1, board_identity_i, 1'b1);
      send(2'h2, board_identity_i, 1'b1);
      send(2'h1, ~board_identity_i, 1'b1);
      u_ats_host_model.tick(1'b1, 1'b1);
      u_ats_host_model.tick(1'b0, 1'b1);
      u_ats_host_model.tick(1'b0, 1'b1);
      send(2'h0, board_identity_i, 1'b0);
      u_ats_host_model.tick(1'b1, 1'b1);
      u_ats_host_model.tick(1'b0, 1'b1);
      send(2'h0, board_identity_i, 1'b1);
      upstream_test_reset_n_i = 1'b0;
      st = 0;
      wt(4);
      chk_st;
      upstream_test_reset_n_i = 1'b1;
      wt(4);
      chk_st;
      rst_i = 1'b1;
      wt(2);
      rst_i = 1'b0;
      wt(4);
      chk_st;
      summarize;
   end
endmodule
